// file: src/dram_bank_cfg_pkg.sv
package dram_bank_cfg_pkg;

    // Port addresses of the indexed configuration pair.
    localparam logic [15:0] INDEX_PORT   = 16'h0022;
    localparam logic [15:0] DATA_PORT    = 16'h0023;

    // Indexes of the bank setup registers.
    localparam logic [7:0]  IDX_BANK0    = 8'h00;
    localparam logic [7:0]  IDX_BANK1    = 8'h01;
    localparam logic [7:0]  IDX_BANK2    = 8'h02;
    localparam int          NUM_BANKS    = 3;

    // Field positions inside a bank setup register.
    localparam int          BIT_ON       = 7;
    localparam int          BIT_RSVD     = 6;
    localparam int          BIT_PAGE     = 5;
    localparam int          BIT_UNEVEN   = 4;
    localparam int          BIT_BUS      = 3;
    localparam int          SIZE_HI      = 2;
    localparam int          SIZE_LO      = 0;

    // Reset values.
    localparam logic [7:0]  BANK_RESET   = 8'h00;
    localparam logic [7:0]  INDEX_RESET  = 8'h00;

    // Device size codes and the address bits of the smallest device.
    localparam logic [2:0]  SIZE_256K    = 3'h0;
    localparam logic [2:0]  SIZE_RSVD    = 3'h7;
    localparam logic [4:0]  BASE_ABITS   = 5'h12;

endpackage : dram_bank_cfg_pkg

// file: src/dram_bank_config.sv
`timescale 1ns/1ps
// Summary of operation
// - Bank one setup answers at index 01h.
// - Disabled bank never receives refresh cycles.
// - Bank two enable claims upper strobe pins.
// - Bus size bit selects 16 or 32 bits.
// - Wide bank zero/one claims upper strobe pins.
// - Bit five selects fast page or EDO.
// - Address-bit count follows each bank's size field.
// - Size codes 256K through 16M, 111 reserved.
module dram_bank_config #(
    parameter int NB = dram_bank_cfg_pkg::NUM_BANKS
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [15:0]    io_addr,
    input  wire logic           io_write,
    input  wire logic           io_read,
    input  wire logic [7:0]     io_wdata,
    input  wire logic           refresh_global_on,
    output logic      [7:0]     io_rdata,
    output logic                io_claim,
    output logic      [NB-1:0]  bank_on,
    output logic      [NB-1:0]  bank_page_kind,
    output logic      [NB-1:0]  bank_uneven_addr,
    output logic      [NB-1:0]  bank_bus_size,
    output logic      [3*NB-1:0] bank_device_size,
    output logic      [5*NB-1:0] bank_addr_bits,
    output logic      [NB-1:0]  bank_size_valid,
    output logic      [NB-1:0]  bank_refresh_ok,
    output logic                upper_pins_on,
    output logic                key_matrix_row_lines_free
);

    logic [7:0]      index;
    logic [7:0]      setup [NB];
    logic [7:0]      next_index;
    logic [7:0]      next_setup [NB];
    logic [7:0]      next_rdata;
    logic            next_claim;
    logic [NB-1:0]   next_on;
    logic [NB-1:0]   next_page;
    logic [NB-1:0]   next_uneven;
    logic [NB-1:0]   next_bus;
    logic [3*NB-1:0] next_size;
    logic [5*NB-1:0] next_abits;
    logic [NB-1:0]   next_valid;
    logic [NB-1:0]   next_refresh;
    logic            next_upper;
    logic            idx_hit;

    always_comb begin
        idx_hit    = index < 8'(NB);
        next_index = index;
        next_rdata = 8'h00;
        next_claim = 1'b0;
        for (int b = 0; b < NB; b++) begin
            next_setup[b] = setup[b];
        end
        if (io_write && io_addr == dram_bank_cfg_pkg::INDEX_PORT) begin
            next_index = io_wdata;
        end
        if (io_write && io_addr == dram_bank_cfg_pkg::DATA_PORT
                && idx_hit) begin
            // The reserved bit is stored so read-modify-write keeps it.
            next_setup[index[1:0]] = io_wdata;
        end
        if (io_read && io_addr == dram_bank_cfg_pkg::INDEX_PORT) begin
            next_rdata = index;
            next_claim = 1'b1;
        end
        if (io_read && io_addr == dram_bank_cfg_pkg::DATA_PORT
                && idx_hit) begin
            next_rdata = setup[index[1:0]];
            next_claim = 1'b1;
        end
    end

    // Per-bank field decode from the next-state setup values, registered below.
    for (genvar g = 0; g < NB; g++) begin : g_bank
        logic [2:0] sz;
        assign sz = next_setup[g][dram_bank_cfg_pkg::SIZE_HI:
                                  dram_bank_cfg_pkg::SIZE_LO];
        always_comb begin
            next_on[g]     = next_setup[g][dram_bank_cfg_pkg::BIT_ON];
            next_page[g]   = next_setup[g][dram_bank_cfg_pkg::BIT_PAGE];
            next_uneven[g] = next_setup[g][dram_bank_cfg_pkg::BIT_UNEVEN];
            next_bus[g]    = next_setup[g][dram_bank_cfg_pkg::BIT_BUS];
            next_size[3*g +: 3] = sz;
            next_valid[g]  = sz != dram_bank_cfg_pkg::SIZE_RSVD;
            next_abits[5*g +: 5] = next_valid[g]
                ? 5'(dram_bank_cfg_pkg::BASE_ABITS + 5'(sz))
                : 5'h00;
            next_refresh[g] = next_on[g] && refresh_global_on;
        end
    end

    always_comb begin
        next_upper = next_on[2] || next_bus[0] || next_bus[1];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            index            <= dram_bank_cfg_pkg::INDEX_RESET;
            for (int b = 0; b < NB; b++) begin
                setup[b]     <= dram_bank_cfg_pkg::BANK_RESET;
            end
            io_rdata         <= 8'h00;
            io_claim         <= 1'b0;
            bank_on          <= '0;
            bank_page_kind   <= '0;
            bank_uneven_addr <= '0;
            bank_bus_size    <= '0;
            bank_device_size <= '0;
            bank_addr_bits   <= '0;
            bank_size_valid  <= '0;
            bank_refresh_ok  <= '0;
            upper_pins_on    <= 1'b0;
            key_matrix_row_lines_free <= 1'b0;
        end else begin
            index            <= next_index;
            for (int b = 0; b < NB; b++) begin
                setup[b]     <= next_setup[b];
            end
            io_rdata         <= next_rdata;
            io_claim         <= next_claim;
            bank_on          <= next_on;
            bank_page_kind   <= next_page;
            bank_uneven_addr <= next_uneven;
            bank_bus_size    <= next_bus;
            bank_device_size <= next_size;
            bank_addr_bits   <= next_abits;
            bank_size_valid  <= next_valid;
            bank_refresh_ok  <= next_refresh;
            upper_pins_on    <= next_upper;
            key_matrix_row_lines_free <= !next_upper;
        end
    end

    // Checks.
    sequence s_idx1;
        io_write && io_addr == dram_bank_cfg_pkg::INDEX_PORT
            && io_wdata == dram_bank_cfg_pkg::IDX_BANK1;
    endsequence

    sequence s_data_wr;
        io_write && io_addr == dram_bank_cfg_pkg::DATA_PORT && !io_read;
    endsequence

    sequence s_bank1_wr;
        s_idx1 ##1 s_data_wr;
    endsequence

    AST_BANK1_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        s_bank1_wr
        |=> bank_on[1] == $past(io_wdata[7])
            && bank_device_size[5:3] == $past(io_wdata[2:0]))
        else $error("Bank one write not applied.");

    AST_BANK1_READ: assert property (@(posedge clk) disable iff (!rst_n)
        s_idx1 ##1 (io_read && io_addr == dram_bank_cfg_pkg::DATA_PORT
            && !io_write)
        |=> io_claim && io_rdata[7] == bank_on[1]
            && io_rdata[5] == bank_page_kind[1])
        else $error("Bank one read returned wrong value.");

    AST_REFRESH_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        !bank_on[0] |-> !bank_refresh_ok[0])
        else $error("Refresh allowed to disabled bank.");

    AST_BANK2_PINS: assert property (@(posedge clk) disable iff (!rst_n)
        bank_on[2] |-> upper_pins_on && !key_matrix_row_lines_free)
        else $error("Bank two enable did not claim pins.");

    AST_WIDE_PINS: assert property (@(posedge clk) disable iff (!rst_n)
        (bank_bus_size[0] || bank_bus_size[1]) |-> upper_pins_on)
        else $error("Wide bank did not claim pins.");

    AST_PINS_FREE: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && !bank_on[2] && bank_bus_size[1:0] == 2'b00
        |-> !upper_pins_on && key_matrix_row_lines_free)
        else $error("Pins claimed without cause.");

    AST_SIZE_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
        bank_size_valid[0] |-> bank_addr_bits[4:0]
            == 5'(dram_bank_cfg_pkg::BASE_ABITS
                + 5'(bank_device_size[2:0])))
        else $error("Size decode wrong.");

    AST_SIZE_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
        bank_device_size[2:0] == dram_bank_cfg_pkg::SIZE_RSVD
        |-> !bank_size_valid[0])
        else $error("Reserved size marked valid.");

    AST_RESET_ZERO: assert property (@(posedge clk)
        $rose(rst_n) |-> bank_on == '0 && bank_bus_size == '0
            && bank_page_kind == '0 && bank_device_size == '0)
        else $error("Bank fields not zero after reset.");

    AST_B1_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
        s_bank1_wr |=> bank_page_kind[1] == $past(io_wdata[5]))
        else $error("Bank one page kind not applied.");

    AST_B1_BUS: assert property (@(posedge clk) disable iff (!rst_n)
        s_bank1_wr |=> bank_bus_size[1] == $past(io_wdata[3]))
        else $error("Bank one bus size not applied.");

    AST_REFRESH_ON: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> bank_refresh_ok
            == (bank_on & {NB{$past(refresh_global_on)}}))
        else $error("Refresh qualifier does not follow enable.");

    AST_NO_CLAIM: assert property (@(posedge clk) disable iff (!rst_n)
        !io_read |=> !io_claim && io_rdata == 8'h00)
        else $error("Read answer without a read.");

    AST_ROWS_INV: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> key_matrix_row_lines_free == !upper_pins_on)
        else $error("Row lines and upper pins disagree.");

endmodule : dram_bank_config

// file: tb/dram_devices.sv
`timescale 1ns/1ps
module dram_devices #(
    parameter logic [8:0] FITTED = 9'h0d1
) (
    input  wire logic [14:0] bank_addr_bits,
    output logic      [8:0]  fitted_size,
    output logic      [2:0]  size_match
);
    // Depth codes of the devices fitted in banks two, one and zero.
    assign fitted_size = FITTED;
    always_comb begin
        for (int n = 0; n < 3; n++) begin
            size_match[n] = bank_addr_bits[5*n+:5] == 5'h12 + FITTED[3*n+:3];
        end
    end
endmodule : dram_devices

// file: tb/dram_bank_config_bench.sv
`timescale 1ns/1ps
module dram_bank_config_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic        io_write = 1'b0;
    logic        io_read = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic        refresh_global_on = 1'b0;
    logic [7:0]  io_rdata;
    logic        io_claim, upper_pins_on, key_matrix_row_lines_free;
    logic [2:0]  bank_on, bank_page_kind, bank_uneven_addr, bank_bus_size;
    logic [2:0]  bank_size_valid, bank_refresh_ok, size_match;
    logic [8:0]  bank_device_size, fitted_size;
    logic [14:0] bank_addr_bits;
    logic [31:0] seed = 32'h690a;
    int          errors = 0;
    int          cmp_count = 0;
    logic [7:0]  m [3] = '{8'h00, 8'h00, 8'h00};
    always #4 clk = ~clk;
    dram_bank_config dram_bank_config_i (.clk, .rst_n, .io_addr, .io_write,
        .io_read, .io_wdata, .refresh_global_on, .io_rdata, .io_claim,
        .bank_on, .bank_page_kind, .bank_uneven_addr, .bank_bus_size,
        .bank_device_size, .bank_addr_bits, .bank_size_valid,
        .bank_refresh_ok, .upper_pins_on, .key_matrix_row_lines_free);
    dram_devices dram_devices_i (.bank_addr_bits, .fitted_size, .size_match);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic access(input logic [15:0] a, input logic [7:0] d, logic w);
        @(posedge clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_write = w;
        io_read = !w;
        @(posedge clk);
        #1;
        io_write = 1'b0;
        io_read = 1'b0;
    endtask : access
    task automatic rd(input logic [7:0] idx, d, input logic cl);
        access(16'h0022, idx, 1'b1);
        access(16'h0023, 8'h00, 1'b0);
        chk("rdata", io_rdata, d);
        chk("claim", io_claim, cl);
    endtask : rd
    task automatic outs();
        logic [2:0] e [5];
        logic [8:0] sz;
        logic [14:0] ab;
        logic        up;
        for (int n = 0; n < 3; n++) begin
            e[0][n] = m[n][7];
            e[1][n] = m[n][5];
            e[2][n] = m[n][4];
            e[3][n] = m[n][3];
            e[4][n] = m[n][2:0] != 3'h7;
            sz[3*n+:3] = m[n][2:0];
            ab[5*n+:5] = e[4][n] ? 5'h12 + m[n][2:0] : 5'h00;
        end
        chk("on", bank_on, e[0]);
        chk("page", bank_page_kind, e[1]);
        chk("uneven", bank_uneven_addr, e[2]);
        chk("bus", bank_bus_size, e[3]);
        chk("size", bank_device_size, sz);
        chk("abits", bank_addr_bits, ab);
        chk("valid", bank_size_valid, e[4]);
        up = m[2][7] | m[0][3] | m[1][3];
        chk("upper", upper_pins_on, up);
        chk("rows", key_matrix_row_lines_free, !up);
        @(posedge clk);
        #1;
        chk("refresh", bank_refresh_ok, e[0] & {3{refresh_global_on}});
    endtask : outs
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    initial begin
        int n;
        logic [31:0] r;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("reset", {bank_on, bank_page_kind, bank_bus_size}, 9'h000);
        @(posedge clk);
        #1;
        outs();
        for (n = 0; n < 4; n++) rd(n[7:0], 8'h00, n < 3);
        for (n = 0; n < 3; n++) begin
            m[n] = {5'h10, fitted_size[3*n+:3]};
            access(16'h0022, n[7:0], 1'b1);
            access(16'h0023, m[n], 1'b1);
        end
        chk("fitted", size_match, 3'h7);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            n = int'(r[31:8] % 3);
            if (r[2:0] == 3'h0) r[4] = 1'b0;
            refresh_global_on = r[30];
            access(16'h0022, n[7:0], 1'b1);
            access(16'h0023, r[7:0], 1'b1);
            m[n] = r[7:0];
            outs();
            rd(n[7:0], m[n], 1'b1);
        end
        access(16'h0023, 8'hff, 1'b1);
        m[n] = 8'hff;
        access(16'h0022, 8'h03, 1'b1);
        access(16'h0022, 8'h00, 1'b0);
        chk("index", io_rdata, 8'h03);
        access(16'h0023, 8'hff, 1'b1);
        rd(8'h03, 8'h00, 1'b0);
        outs();
        stop_test();
    end
endmodule : dram_bank_config_bench
